// ==== design/sorc_ctrl.sv ====
// Purpose: Safety output pair stop and restart control with interlock
// Assumes: obj_det comes from scan evaluation on clk; button and slave pins are async
// Notes: Times counted in half-millisecond ticks from one divider
//
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`include "sorc_defines.svh"
module sorc_ctrl #(
    parameter int unsigned HALF_MS_CYCLES = `SORC_HALF_MS_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic obj_det,
    input wire logic restart_btn,
    input wire logic slave_stop,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output sorc_pkg::sorc_pair_t pair1,
    output sorc_pkg::sorc_pair_t pair2,
    output logic interlock_lamp,
    output logic scan_tick,
    output logic irq
);

    // ---------------------------------------------------------------
    // Elaboration checks
    // ---------------------------------------------------------------
    if (HALF_MS_CYCLES < 2) begin : g_bad_div
        $error("HALF_MS_CYCLES must be at least 2");
    end

    // ---------------------------------------------------------------
    // Functions
    // ---------------------------------------------------------------
    function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [31:0] lo,
                                            input logic [31:0] hi);
        logic [31:0] r;
        r = (v < lo) ? lo : ((v > hi) ? hi : v);
        return r[15:0];
    endfunction : clamp16

    // Response time in half-millisecond ticks
    function automatic logic [11:0] resp_ticks(input logic [1:0] code, input logic [5:0] scans,
                                               input logic [1:0] slaves, input logic by_slave);
        logic [11:0] per;
        logic [11:0] lat;
        per = 12'(`SORC_SCAN_BASE_TICKS) + {10'h000, code};
        lat = by_slave ? 12'(slaves) * 12'(2 * `SORC_LATENCY_MS) : 12'h000;
        return per * {6'h00, scans} + 12'(2 * `SORC_FIXED_MS) + lat;
    endfunction : resp_ticks

    // ---------------------------------------------------------------
    // Timebase and pin synchronisers
    // ---------------------------------------------------------------
    logic half_tick;

    sorc_div #(
        .N(HALF_MS_CYCLES)
    ) u_div (
        .clk(clk),
        .arst_n(arst_n),
        .tick(half_tick)
    );

    logic btn_m_q;
    logic btn_s_q;
    logic btn_d_q;
    logic slv_m_q;
    logic slv_s_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            btn_m_q <= 1'b0;
            btn_s_q <= 1'b0;
            btn_d_q <= 1'b0;
            slv_m_q <= 1'b0;
            slv_s_q <= 1'b0;
        end else begin
            btn_m_q <= restart_btn;
            btn_s_q <= btn_m_q;
            btn_d_q <= btn_s_q;
            slv_m_q <= slave_stop;
            slv_s_q <= slv_m_q;
        end
    end

    // ---------------------------------------------------------------
    // Registers
    // ---------------------------------------------------------------
    sorc_pkg::sorc_cfg_t cfg_q;
    logic [5:0] scans_q;
    logic [15:0] delay_q;
    logic [2:0] irq_stat_q;
    logic [2:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic irq_q;

    wire wr_ctrl = reg_wr && (reg_addr == `SORC_OFS_CTRL);
    wire wr_scans = reg_wr && (reg_addr == `SORC_OFS_SCANS);
    wire wr_delay = reg_wr && (reg_addr == `SORC_OFS_DELAY);
    wire wr_istat = reg_wr && (reg_addr == `SORC_OFS_IRQ_STAT);
    wire wr_imask = reg_wr && (reg_addr == `SORC_OFS_IRQ_MASK);

    // Out-of-range values are clamped so the block can never run unsafe settings
    wire [15:0] scans_w = clamp16(reg_wdata, `SORC_SCANS_MIN, `SORC_SCANS_MAX);
    wire [15:0] delay_w = clamp16(reg_wdata, `SORC_DELAY_MIN_MS, `SORC_DELAY_MAX_MS);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q <= '0;
            scans_q <= `SORC_RST_SCANS;
            delay_q <= `SORC_RST_DELAY;
            irq_mask_q <= 3'h0;
        end else begin
            if (wr_ctrl) begin
                cfg_q.manual <= reg_wdata[`SORC_CTRL_MANUAL];
                cfg_q.code <= reg_wdata[`SORC_CTRL_CODE_LO +: 2];
                cfg_q.slaves <= reg_wdata[`SORC_CTRL_SLV_LO +: 2];
            end
            if (wr_scans) begin
                scans_q <= scans_w[5:0];
            end
            if (wr_delay) begin
                delay_q <= delay_w;
            end
            if (wr_imask) begin
                irq_mask_q <= reg_wdata[2:0];
            end
        end
    end

    // ---------------------------------------------------------------
    // Scan period
    // ---------------------------------------------------------------
    logic [6:0] scan_cnt_q;
    logic scan_tick_q;
    wire [6:0] period_w = 7'(`SORC_SCAN_BASE_TICKS) + {5'h00, cfg_q.code};
    wire scan_end = half_tick && (scan_cnt_q >= period_w - 7'h01);
    wire scan_hit = scan_end && obj_det;
    wire scan_clr = scan_end && !obj_det;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            scan_cnt_q <= 7'h00;
            scan_tick_q <= 1'b0;
        end else begin
            if (half_tick) begin
                scan_cnt_q <= scan_end ? 7'h00 : scan_cnt_q + 7'h01;
            end
            scan_tick_q <= scan_end;
        end
    end

    // ---------------------------------------------------------------
    // Detection count
    // ---------------------------------------------------------------
    sorc_pkg::sorc_state_t state_q;
    sorc_pkg::sorc_state_t state_d;
    logic [5:0] det_cnt_q;
    wire [5:0] det_next = det_cnt_q + 6'h01;
    // Single dusty scans only count up; one clear scan restarts the count
    wire det_trip = scan_hit && (det_next >= scans_q);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            det_cnt_q <= 6'h00;
        end else if (scan_end) begin
            if (!obj_det || state_q != sorc_pkg::ST_RUN) begin
                det_cnt_q <= 6'h00;
            end else if (det_cnt_q != 6'(`SORC_SCANS_MAX)) begin
                det_cnt_q <= det_next;
            end
        end
    end

    // ---------------------------------------------------------------
    // Clear-area timer
    // ---------------------------------------------------------------
    logic area_busy_q;
    logic [16:0] clear_cnt_q;
    wire [16:0] delay_ticks = {delay_q, 1'b0};
    wire rec_done = !area_busy_q && (clear_cnt_q >= delay_ticks);

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            area_busy_q <= 1'b1;
            clear_cnt_q <= 17'h00000;
        end else begin
            if (scan_hit) begin
                area_busy_q <= 1'b1;
                clear_cnt_q <= 17'h00000;
            end else if (scan_clr) begin
                area_busy_q <= 1'b0;
            end
            if (!scan_hit && half_tick && !area_busy_q && !rec_done) begin
                clear_cnt_q <= clear_cnt_q + 17'h00001;
            end
        end
    end

    // ---------------------------------------------------------------
    // Restart button timing
    // ---------------------------------------------------------------
    logic [13:0] press_cnt_q;
    logic press_live_q;
    localparam logic [13:0] PRESS_MIN_T = 14'(2 * `SORC_PRESS_MIN_MS);
    localparam logic [13:0] PRESS_MAX_T = 14'(2 * `SORC_PRESS_MAX_MS);
    wire btn_rise = btn_s_q && !btn_d_q;
    wire btn_fall = !btn_s_q && btn_d_q;
    wire press_in_range = (press_cnt_q >= PRESS_MIN_T) && (press_cnt_q <= PRESS_MAX_T);
    // Release, not press, is the restart moment
    wire press_ok = btn_fall && press_live_q && press_in_range;
    wire press_bad = btn_fall && !press_ok;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            press_cnt_q <= 14'h0000;
            press_live_q <= 1'b0;
        end else begin
            if (btn_rise) begin
                press_cnt_q <= 14'h0000;
            end else if (btn_s_q && half_tick && press_cnt_q <= PRESS_MAX_T) begin
                press_cnt_q <= press_cnt_q + 14'h0001;
            end
            // A press counts only if it starts and ends while restart is permitted
            if (state_q != sorc_pkg::ST_PERMIT) begin
                press_live_q <= 1'b0;
            end else if (btn_rise) begin
                press_live_q <= 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Interlock state machine
    // ---------------------------------------------------------------
    wire stop_evt = (state_q == sorc_pkg::ST_RUN) && det_trip;
    wire go_evt = (state_d == sorc_pkg::ST_RUN) && (state_q != sorc_pkg::ST_RUN);

    always_comb begin
        state_d = state_q;
        case (state_q)
            sorc_pkg::ST_INIT: begin
                if (scan_clr) begin
                    state_d = sorc_pkg::ST_RUN;
                end
            end
            sorc_pkg::ST_RUN: begin
                if (det_trip) begin
                    state_d = sorc_pkg::ST_BLOCKED;
                end
            end
            sorc_pkg::ST_BLOCKED: begin
                if (scan_clr) begin
                    state_d = cfg_q.manual ? sorc_pkg::ST_PERMIT : sorc_pkg::ST_RECOVER;
                end
            end
            sorc_pkg::ST_RECOVER: begin
                if (scan_hit) begin
                    state_d = sorc_pkg::ST_BLOCKED;
                end else if (rec_done) begin
                    state_d = sorc_pkg::ST_RUN;
                end
            end
            sorc_pkg::ST_PERMIT: begin
                if (scan_hit) begin
                    state_d = sorc_pkg::ST_BLOCKED;
                end else if (press_ok) begin
                    state_d = sorc_pkg::ST_RUN;
                end
            end
            default: begin
                state_d = sorc_pkg::ST_INIT;
            end
        endcase
    end

    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    logic pair1_on_q;
    logic pair2_on_q;
    logic lamp_q;
    logic by_slave_q;
    logic [11:0] resp_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= sorc_pkg::ST_INIT;
            pair1_on_q <= 1'b0;
            pair2_on_q <= 1'b0;
            lamp_q <= 1'b0;
            by_slave_q <= 1'b0;
            resp_q <= 12'h000;
        end else begin
            state_q <= state_d;
            pair1_on_q <= (state_d == sorc_pkg::ST_RUN);
            lamp_q <= (state_d == sorc_pkg::ST_PERMIT);
            // Second pair restarts on the clear-delay timer or on any entry to run except the first one from init, whichever comes first
            if (stop_evt || state_q == sorc_pkg::ST_INIT) begin
                pair2_on_q <= 1'b0;
            end else if (go_evt || rec_done) begin
                pair2_on_q <= 1'b1;
            end
            if (stop_evt) begin
                by_slave_q <= slv_s_q;
            end
            resp_q <= resp_ticks(cfg_q.code, scans_q, cfg_q.slaves, by_slave_q);
        end
    end

    // ---------------------------------------------------------------
    // Interrupts and read data
    // ---------------------------------------------------------------
    wire [2:0] irq_evt = {press_bad, go_evt, stop_evt};
    wire [2:0] irq_clr = wr_istat ? reg_wdata[2:0] : 3'h0;
    wire [7:0] status_w = {1'b0, by_slave_q, lamp_q, pair2_on_q, pair1_on_q, state_q};
    logic [31:0] rdata_d_w;

    always_comb begin
        case (reg_addr)
            `SORC_OFS_CTRL: rdata_d_w = {27'h0, cfg_q.slaves, cfg_q.code, cfg_q.manual};
            `SORC_OFS_SCANS: rdata_d_w = {26'h0, scans_q};
            `SORC_OFS_DELAY: rdata_d_w = {16'h0000, delay_q};
            `SORC_OFS_STATUS: rdata_d_w = {24'h000000, status_w};
            `SORC_OFS_RESP: rdata_d_w = {20'h00000, resp_q};
            `SORC_OFS_IRQ_STAT: rdata_d_w = {29'h0, irq_stat_q};
            `SORC_OFS_IRQ_MASK: rdata_d_w = {29'h0, irq_mask_q};
            default: rdata_d_w = 32'h00000000;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_stat_q <= 3'h0;
            irq_q <= 1'b0;
            rdata_q <= 32'h00000000;
        end else begin
            // New events win over a write-one-to-clear in the same cycle
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
            irq_q <= |(((irq_stat_q & ~irq_clr) | irq_evt) & irq_mask_q);
            rdata_q <= reg_rd ? rdata_d_w : 32'h00000000;
        end
    end

    assign reg_rdata = rdata_q;
    assign pair1 = '{ch_a: pair1_on_q, ch_b: pair1_on_q};
    assign pair2 = '{ch_a: pair2_on_q, ch_b: pair2_on_q};
    assign interlock_lamp = lamp_q;
    assign scan_tick = scan_tick_q;
    assign irq = irq_q;

endmodule : sorc_ctrl

// ==== design/sorc_defines.svh ====
// Purpose: Constants of the safety output restart control
// Assumes: 50 MHz clock, half-millisecond timebase
// Notes: Offsets are byte addresses on the plain register port
//
// Behaviour
// - An object confirmed in the protected area switches both safety output channels off; here pair2 stays on if an object enters while restart is permitted.
// - Restart back to on is either automatic or manual, chosen by software.
// - Automatic restart turns outputs on after a clear delay of 200 to 60000 ms.
// - Manual restart keeps outputs off until a button press after the area clears.
// - A valid button press lasts 500 ms to 4.5 s; the press is timed.
// - After a valid press the outputs turn on at button release.
// - While stopped, restart is permitted if area clear, blocked while object stays.
// - The indicator lamp is lit while restart is permitted.
// - Holding the button while the object remains keeps restart blocked and outputs off.
// - Only the first output pair offers manual restart; the second is automatic.
// - Anti-interference code 0..3 sets scan period 30, 30.5, 31, 31.5 ms.
// - Outputs stop only after the configured 2 to 40 consecutive detecting scans.
// - The scan count may be raised above two to reject brief false detections.
// - Response time is period times scans plus 2 ms plus 10 ms per slave.
// - Slave latency is added only when a slave caused the stop.
// - A system has one master and at most three slave units.
`ifndef SORC_DEFINES_SVH
`define SORC_DEFINES_SVH

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define SORC_CLK_NS 20
`define SORC_TICK_NS 500000
`define SORC_HALF_MS_CYCLES ((`SORC_TICK_NS + `SORC_CLK_NS - 1) / `SORC_CLK_NS)
`define SORC_TICK_US 500
`define SORC_SCAN_BASE_US 30000
`define SORC_SCAN_BASE_TICKS (`SORC_SCAN_BASE_US / `SORC_TICK_US)
`define SORC_PRESS_MIN_MS 500
`define SORC_PRESS_MAX_MS 4500
`define SORC_FIXED_MS 2
`define SORC_LATENCY_MS 10
`define SORC_DELAY_MIN_MS 200
`define SORC_DELAY_MAX_MS 60000
`define SORC_SCANS_MIN 2
`define SORC_SCANS_MAX 40
`define SORC_SLAVES_MAX 3

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define SORC_OFS_CTRL 8'h00
`define SORC_OFS_SCANS 8'h04
`define SORC_OFS_DELAY 8'h08
`define SORC_OFS_STATUS 8'h0c
`define SORC_OFS_RESP 8'h10
`define SORC_OFS_IRQ_STAT 8'h14
`define SORC_OFS_IRQ_MASK 8'h18

// CTRL fields
`define SORC_CTRL_MANUAL 0
`define SORC_CTRL_CODE_LO 1
`define SORC_CTRL_SLV_LO 3

// Reset values
`define SORC_RST_SCANS 6'h02
`define SORC_RST_DELAY 16'h00c8

// Interrupt bits
`define SORC_IRQ_STOP 0
`define SORC_IRQ_RESTART 1
`define SORC_IRQ_REJECT 2

`endif

// ==== design/sorc_pkg.sv ====
// Purpose: Types of the safety output restart control
// Assumes: Constants live in sorc_defines.svh
// Notes: Nothing here is imported; use sorc_pkg::name
package sorc_pkg;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef struct packed {
        logic ch_a;
        logic ch_b;
    } sorc_pair_t;

    typedef enum logic [2:0] {
        ST_INIT,
        ST_RUN,
        ST_BLOCKED,
        ST_RECOVER,
        ST_PERMIT
    } sorc_state_t;

    typedef struct packed {
        logic manual;
        logic [1:0] code;
        logic [1:0] slaves;
    } sorc_cfg_t;

endpackage : sorc_pkg

// ==== design/sorc_div.sv ====
// Purpose: Divider giving a one-cycle enable pulse every N clocks
// Assumes: N of at least 2
// Notes: Pulse comes from a register
`timescale 1ns/1ps
module sorc_div #(
    parameter int unsigned N = 25000
) (
    input wire logic clk,
    input wire logic arst_n,
    output logic tick
);

    // ---------------------------------------------------------------
    // Counter
    // ---------------------------------------------------------------
    localparam int unsigned W = (N > 2) ? $clog2(N) : 1;

    logic [W-1:0] cnt_q;
    logic tick_q;
    wire last = (cnt_q == W'(N - 1));

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= '0;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= last ? '0 : cnt_q + W'(1);
            tick_q <= last;
        end
    end

    assign tick = tick_q;

endmodule : sorc_div

// ==== verif/sorc_ctrl_checker.sv ====
// Purpose: Port-level assertions for the safety output restart control
// Assumes: Single clock domain, asynchronous active-low reset
// Notes: Scan period checked only after a first scan end, phase is free
`timescale 1ns/1ps
module sorc_ctrl_checker #(
    parameter int unsigned HALF_MS_CYCLES = 4
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic obj_det,
    input wire logic restart_btn,
    input wire logic slave_stop,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    input wire sorc_pkg::sorc_pair_t pair1,
    input wire sorc_pkg::sorc_pair_t pair2,
    input wire logic interlock_lamp,
    input wire logic scan_tick,
    input wire logic irq
);
    // ---------------------------------------------------------------
    // Helper logic
    // ---------------------------------------------------------------
    logic [15:0] gap_q;
    logic seen_q;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gap_q <= 16'h0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= scan_tick ? 16'h0 : gap_q + 16'h1;
            seen_q <= seen_q | scan_tick;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    a_pair_chan_equal: assert property (
        pair1.ch_a == pair1.ch_b && pair2.ch_a == pair2.ch_b)
        else $error("safety channels of a pair disagree");
    a_lamp_outputs_off: assert property (
        interlock_lamp |-> !pair1.ch_a)
        else $error("lamp lit while first pair on");
    a_stop_at_scan: assert property (
        $fell(pair1.ch_a) |-> scan_tick)
        else $error("stop not at a scan end");
    a_stop_both_pairs: assert property (
        $fell(pair1.ch_a) |-> !pair2.ch_a)
        else $error("second pair still on at stop");
    a_release_restart: assert property (
        $rose(pair1.ch_a) && $past(interlock_lamp) |-> !restart_btn)
        else $error("manual restart before button release");
    a_rdata_idle_zero: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0)
        else $error("read data outside read answer cycle");
    a_scan_period: assert property (
        scan_tick && seen_q |-> int'(gap_q) + 1 >= 60 * HALF_MS_CYCLES
            && int'(gap_q) + 1 <= 63 * HALF_MS_CYCLES
            && (int'(gap_q) + 1) % HALF_MS_CYCLES == 0)
        else $error("scan period out of range");
    a_init_off: assert property (
        !seen_q && !scan_tick |-> !pair1.ch_a && !pair2.ch_a)
        else $error("outputs on before first scan");

    c_stop: cover property ($fell(pair1.ch_a));
    c_permit: cover property ($rose(interlock_lamp));
    c_manual_on: cover property ($rose(pair1.ch_a) && $past(interlock_lamp));
endmodule : sorc_ctrl_checker

bind sorc_ctrl sorc_ctrl_checker #(.HALF_MS_CYCLES(HALF_MS_CYCLES)) u_checker (
    .clk(clk), .arst_n(arst_n), .obj_det(obj_det), .restart_btn(restart_btn),
    .slave_stop(slave_stop), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pair1(pair1), .pair2(pair2),
    .interlock_lamp(interlock_lamp), .scan_tick(scan_tick), .irq(irq));

// ==== verif/sorc_partner.sv ====
// Purpose: Operator restart button beside the machine controller
// Assumes: Press length given in clock cycles by the caller
// Notes: Button is a plain contact, released means low
`timescale 1ns/1ps
module sorc_partner (
    input wire logic clk,
    output logic restart_btn
);
    // ---------------------------------------------------------------
    // Button
    // ---------------------------------------------------------------
    initial restart_btn = 1'b0;

    // Held whole cycles; caller picks legal or deliberately bad lengths
    task press(input int cycles);
        @(posedge clk);
        restart_btn <= 1'b1;
        repeat (cycles) @(posedge clk);
        restart_btn <= 1'b0;
    endtask : press
endmodule : sorc_partner

// ==== verif/sorc_ctrl_bench.sv ====
// Purpose: Self-checking bench of the safety output restart control
// Assumes: Half-millisecond tick shrunk to 4 clocks, all times scale
// Notes: Each scenario starts from a fresh reset
`timescale 1ns/1ps
module sorc_ctrl_bench;
    localparam int unsigned H = 4;
    logic clk, arst_n, obj_det, slave_stop, reg_wr, reg_rd;
    logic interlock_lamp, scan_tick, irq, restart_btn;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, rd_q;
    sorc_pkg::sorc_pair_t pair1, pair2;
    int miscompares = 0;
    int checked = 0;
    int gap;

    sorc_ctrl #(.HALF_MS_CYCLES(H)) DUT (
        .clk(clk), .arst_n(arst_n), .obj_det(obj_det), .restart_btn(restart_btn),
        .slave_stop(slave_stop), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pair1(pair1),
        .pair2(pair2), .interlock_lamp(interlock_lamp), .scan_tick(scan_tick), .irq(irq));
    sorc_partner PEER (.clk(clk), .restart_btn(restart_btn));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // Shared tasks
    // ---------------------------------------------------------------
    task give_verdict;
        if (miscompares == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : give_verdict

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 rd_q = reg_rdata;
    endtask : rd

    // Waits for the next scan end, bounded by more than the longest scan
    task tick(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (scan_tick !== 1'b1 && n < 400);
        if (scan_tick !== 1'b1) begin
            miscompares++;
            give_verdict();
        end
    endtask : tick

    task ticks(input int k);
        repeat (k) tick(gap);
    endtask : ticks

    task wait_p1(input logic v, input int lim);
        int n;
        n = 0;
        while (pair1.ch_a !== v && n < lim) begin
            @(posedge clk);
            #1 n++;
        end
        chk("pair1", v, pair1.ch_a);
        if (pair1.ch_a !== v) begin
            give_verdict();
        end
    endtask : wait_p1

    task set_obj(input logic det, input logic slv);
        @(posedge clk);
        obj_det <= det;
        slave_stop <= slv;
    endtask : set_obj

    task do_reset(input logic [31:0] ctrl);
        @(posedge clk);
        arst_n <= 1'b0;
        obj_det <= 1'b0;
        slave_stop <= 1'b0;
        repeat (10) @(posedge clk);
        arst_n <= 1'b1;
        wr(8'h00, ctrl);
    endtask : do_reset

    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task s_regs;
        do_reset(32'h0);
        rd(8'h04);
        chk("scans reset", 32'h2, rd_q);
        rd(8'h08);
        chk("delay reset", 32'hc8, rd_q);
        wr(8'h04, 32'h1);
        rd(8'h04);
        chk("scans low", 32'h2, rd_q);
        wr(8'h04, 32'h29);
        rd(8'h04);
        chk("scans high", 32'h28, rd_q);
        wr(8'h08, 32'hea61);
        rd(8'h08);
        chk("delay high", 32'hea60, rd_q);
        wr(8'h08, 32'hc7);
        rd(8'h08);
        chk("delay low", 32'hc8, rd_q);
        wr(8'h00, 32'h1e);
        wr(8'h10, 32'h0);
        rd(8'h10);
        chk("resp max", 32'd2524, rd_q);
        rd(8'h1c);
        chk("unmapped", 32'h0, rd_q);
    endtask : s_regs

    task s_scan;
        do_reset(32'h0);
        for (int c = 0; c < 4; c++) begin
            wr(8'h00, 32'(c << 1));
            ticks(2);
            tick(gap);
            chk("scan period", 32'((60 + c) * H), 32'(gap));
        end
    endtask : s_scan

    task s_auto;
        do_reset(32'h10);
        wr(8'h04, 32'h3);
        chk("init off", 0, pair1.ch_a);
        tick(gap);
        chk("run on", 1, pair1.ch_a);
        rd(8'h10);
        chk("resp master", 32'd184, rd_q);
        set_obj(1'b1, 1'b0);
        ticks(2);
        set_obj(1'b0, 1'b0);
        tick(gap);
        chk("short detect", 1, pair1.ch_a);
        set_obj(1'b1, 1'b1);
        ticks(3);
        chk("stop pair1", 0, pair1.ch_a);
        chk("stop pair2", 0, pair2.ch_a);
        chk("irq masked", 0, irq);
        rd(8'h10);
        chk("resp slave", 32'd224, rd_q);
        rd(8'h14);
        chk("irq stat", 3'b011, rd_q[2:0]);
        wr(8'h18, 32'h1);
        cyc(2);
        chk("irq on", 1, irq);
        wr(8'h14, 32'h3);
        cyc(2);
        chk("irq clear", 0, irq);
        set_obj(1'b0, 1'b0);
        tick(gap);
        cyc(400 * H - 8);
        chk("recover early", 0, pair1.ch_a);
        wait_p1(1'b1, 20);
    endtask : s_auto

    task s_manual;
        do_reset(32'h1);
        wr(8'h18, 32'h4);
        tick(gap);
        set_obj(1'b1, 1'b0);
        ticks(2);
        PEER.press(1200 * H);
        cyc(8);
        chk("blocked pair1", 0, pair1.ch_a);
        chk("blocked lamp", 0, interlock_lamp);
        wr(8'h14, 32'h4);
        set_obj(1'b0, 1'b0);
        tick(gap);
        cyc(2);
        chk("permit lamp", 1, interlock_lamp);
        PEER.press(900 * H);
        cyc(8);
        chk("short pair1", 0, pair1.ch_a);
        chk("short lamp", 1, interlock_lamp);
        chk("reject irq", 1, irq);
        wr(8'h14, 32'h4);
        PEER.press(9100 * H);
        cyc(8);
        chk("long pair1", 0, pair1.ch_a);
        chk("auto pair2", 1, pair2.ch_a);
        PEER.press(1100 * H);
        #1 chk("at release", 0, pair1.ch_a);
        wait_p1(1'b1, 8);
    endtask : s_manual

    initial begin
        arst_n = 1'b0;
        obj_det = 1'b0;
        slave_stop = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h0;
        reg_wdata = 32'h0;
        s_regs();
        s_scan();
        s_auto();
        s_manual();
        give_verdict();
    end
endmodule : sorc_ctrl_bench
